//--- core/hcb_pkg.sv
// Constants shared by the host configuration bank and its serial PROM reader
package hcb_pkg;
   // Clock and serial PROM timing
   localparam int CLK_PERIOD_NS = 10; // 100 MHz system clock
   localparam int PROM_SK_HALF_NS = 500; // Least half period of the PROM serial clock
   localparam int PROM_SK_HALF_CYC = (PROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Host register port geometry
   localparam int ADDR_W = 4; // Byte offset within a bank
   localparam int DATA_W = 16; // Host word width
   localparam int BANK_W = 6; // Bank select field width

   // Register offsets
   localparam logic [3:0] OFS_BANK_SEL = 4'hE;
   localparam logic [3:0] OFS_MAC_MID = 4'h2;
   localparam logic [3:0] OFS_MAC_HIGH = 4'h4;
   localparam logic [3:0] OFS_BUS_SPEED = 4'h0;
   localparam logic [3:0] OFS_PROM_CTRL = 4'h2;
   localparam logic [3:0] OFS_SELFTEST = 4'h4;
   localparam logic [3:0] OFS_SOFT_RST = 4'h6;
   localparam logic [3:0] OFS_BUS_WIDTH = 4'h8;

   // Bank numbers
   localparam logic [5:0] BANK_MAC = 6'h02;
   localparam logic [5:0] BANK_CTRL = 6'h03;
   localparam logic [5:0] BANK_RESET = 6'h00;

   // Field positions
   localparam int BIT_PROM_SW_EN = 4;
   localparam int BIT_PROM_DI = 3;
   localparam int BIT_PROM_DO = 2;
   localparam int BIT_PROM_SK = 1;
   localparam int BIT_PROM_CS = 0;
   localparam int BIT_TX_DONE = 12;
   localparam int BIT_TX_FAIL = 11;
   localparam int BIT_RX_DONE = 4;
   localparam int BIT_RX_FAIL = 3;
   localparam int BIT_SOFT_RST = 0;
   localparam int BIT_BUS_WIDTH = 0;
   localparam int CFG_BIT_SPEED = 1;
   localparam int CFG_BIT_WIDTH = 0;

   // Bus speed codes
   localparam logic [1:0] SPEED_125 = 2'h0;
   localparam logic [1:0] SPEED_62P5 = 2'h1;
   localparam logic [1:0] SPEED_41P66 = 2'h2;
   localparam logic [1:0] SPEED_25 = 2'h3;

   // Serial PROM word addresses
   localparam logic [5:0] PROM_W_BASE = 6'h00;
   localparam logic [5:0] PROM_W_MAC_LOW = 6'h01;
   localparam logic [5:0] PROM_W_MAC_MID = 6'h02;
   localparam logic [5:0] PROM_W_MAC_HIGH = 6'h03;
   localparam logic [5:0] PROM_W_CONFIG = 6'h06;

   // Reset and default values
   localparam logic [15:0] BASE_ADDR_DEFAULT = 16'h0300;
   localparam logic [15:0] BASE_ADDR_MASK = 16'hFFE0;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic BUS_WIDTH_DEFAULT = 1'b1;

   // Serial read command framing: start bit then read opcode
   localparam logic [2:0] PROM_CMD_READ = 3'h6;
   localparam int PROM_CMD_BITS = 9;
   localparam int PROM_READ_BITS = 17; // Leading dummy zero then 16 data bits
   localparam logic [4:0] PROM_LAST_BIT = 5'h19;

   // Loader sequencing
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [2:0] LOAD_LAST_STEP = 3'h4;
endpackage

//--- core/hcb_prom_word_reader.sv
// Serial PROM single word reader driving chip select, clock and data out
`timescale 1ns/100ps
`default_nettype none
module hcb_prom_word_reader #(
   parameter int HALF_CYC = hcb_pkg::PROM_SK_HALF_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Request and answer
   input wire logic i_start,
   input wire logic [5:0] i_addr,
   output logic o_busy,
   output logic o_done,
   output logic [15:0] o_data,
   // Serial pins, data in already synchronised
   input wire logic i_di,
   output logic o_cs,
   output logic o_sk,
   output logic o_do
);
   // Elaboration check on the half period
   if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
      $error("HALF_CYC must lie between 2 and 255");
   end

   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_LOW = 3'b010,
      RD_HIGH = 3'b100
   } hcb_rd_state_t;

   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1); // Last count of a half period

   hcb_rd_state_t state, next_state; // Bit phase
   logic [7:0] div, next_div; // Half period counter
   logic [4:0] bit_cnt, next_bit_cnt; // Bit index within the frame
   logic [8:0] shout, next_shout; // Command shifter, drains to zeros
   logic [15:0] shin, next_shin; // Read shifter, dummy bit falls off the top
   logic cs, next_cs;
   logic sk, next_sk;
   logic done, next_done;
   logic [15:0] data, next_data;

   // Next state of the serial frame
   always_comb begin
      next_state = state;
      next_div = div;
      next_bit_cnt = bit_cnt;
      next_shout = shout;
      next_shin = shin;
      next_cs = cs;
      next_sk = sk;
      next_done = 1'b0;
      next_data = data;
      unique case (state)
         RD_IDLE: begin
            // Open a frame with chip select and the first command bit
            if (i_start) begin
               next_shout = {hcb_pkg::PROM_CMD_READ, i_addr};
               next_bit_cnt = 5'h00;
               next_div = 8'h00;
               next_cs = 1'b1;
               next_sk = 1'b0;
               next_state = RD_LOW;
            end
         end
         RD_LOW: begin
            // Data out is stable through the low phase
            if (div == HALF_LAST) begin
               next_div = 8'h00;
               next_sk = 1'b1;
               next_state = RD_HIGH;
            end else begin
               next_div = div + 8'h01;
            end
         end
         RD_HIGH: begin
            // Sample late in the high phase, the part drives after the falling edge
            if (div == HALF_LAST) begin
               next_div = 8'h00;
               next_sk = 1'b0;
               next_shin = {shin[14:0], i_di};
               if (bit_cnt == hcb_pkg::PROM_LAST_BIT) begin
                  next_cs = 1'b0;
                  next_done = 1'b1;
                  next_data = {shin[14:0], i_di};
                  next_state = RD_IDLE;
               end else begin
                  next_bit_cnt = bit_cnt + 5'h01;
                  next_shout = {shout[7:0], 1'b0};
                  next_state = RD_LOW;
               end
            end else begin
               next_div = div + 8'h01;
            end
         end
      endcase
   end

   // Frame registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= RD_IDLE;
         div <= 8'h00;
         bit_cnt <= 5'h00;
         shout <= 9'h000;
         shin <= 16'h0000;
         cs <= 1'b0;
         sk <= 1'b0;
         done <= 1'b0;
         data <= 16'h0000;
      end else begin
         state <= next_state;
         div <= next_div;
         bit_cnt <= next_bit_cnt;
         shout <= next_shout;
         shin <= next_shin;
         cs <= next_cs;
         sk <= next_sk;
         done <= next_done;
         data <= next_data;
      end
   end

   assign o_busy = (state != RD_IDLE);
   assign o_done = done;
   assign o_data = data;
   assign o_cs = cs;
   assign o_sk = sk;
   assign o_do = shout[8];
endmodule
`default_nettype wire

//--- core/hcb_host_config_bank.sv
// Host configuration bank: MAC words, bus speed, serial PROM access, self test, soft reset
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Read/write middle MAC address word
// - Read/write high MAC address word
// - Two-bit speed field selects internal bus rate
// - PROM config bit 1 loads speed 00/11
// - Host may rewrite speed after load
// - PROM off: base 0x300, software sets MAC mid/high
// - PROM on: load base and MAC after reset
// - Software access bit gates host pin control
// - Bit 3 reads live PROM data input
// - Bits 2..0 drive data, clock, select
// - Bit 12 shows transmit self test done
// - Bit 11 shows transmit self test failed
// - Bit 4 shows receive self test done
// - Bit 3 shows receive self test failed
// - Reset bit 0 holds soft reset active
// - Soft reset hits datapath, spares base address
// - PROM on: width bit from config bit 0
// - Width bit: 1 is 16-bit, 0 8-bit
// - PROM words 1..3 load MAC low/mid/high
// - Bank select at 0xE in every bank
module hcb_host_config_bank #(
   parameter int SK_HALF_CYC = hcb_pkg::PROM_SK_HALF_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Host register port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [3:0] i_reg_addr,
   input wire logic [1:0] i_reg_be,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Serial PROM pins
   input wire logic i_prom_enable_pin,
   input wire logic i_prom_data_in_pin,
   output logic o_prom_data_out_pin,
   output logic o_prom_serial_clock_pin,
   output logic o_prom_chip_select_pin,
   // Memory self test results
   input wire logic i_tx_mem_selftest_done,
   input wire logic i_tx_mem_selftest_fail,
   input wire logic i_rx_mem_selftest_done,
   input wire logic i_rx_mem_selftest_fail,
   // Configuration towards the rest of the chip
   output logic [1:0] o_bus_speed_select,
   output logic o_soft_reset,
   output logic [15:0] o_base_addr,
   output logic [15:0] o_host_mac_addr_low,
   output logic [15:0] o_host_mac_addr_mid,
   output logic [15:0] o_host_mac_addr_high,
   output logic o_bus_width_16,
   output logic o_prom_load_busy
);
   typedef enum logic [3:0] {
      LD_SETTLE = 4'b0001,
      LD_ISSUE = 4'b0010,
      LD_WAIT = 4'b0100,
      LD_DONE = 4'b1000
   } hcb_load_state_t;
   logic en_meta, en_sync; // Pin synchronisers: first stage feeds only the second
   logic di_meta, di_sync;
   // Register state
   logic [5:0] bank_select_field, next_bank_select_field; // Active bank
   logic [15:0] host_mac_addr_mid, next_host_mac_addr_mid;
   logic [15:0] host_mac_addr_high, next_host_mac_addr_high;
   logic [15:0] mac_low, next_mac_low; // Loaded only from the PROM here
   logic [15:0] base_addr, next_base_addr;
   logic [1:0] bus_speed_select, next_bus_speed_select;
   logic prom_sw_access_enable, next_prom_sw_access_enable;
   logic [2:0] prom_pin_bits, next_prom_pin_bits; // Data out, clock, select
   logic soft_rst, next_soft_rst;
   logic bus_width_status, next_bus_width_status;
   hcb_load_state_t ld_state, next_ld_state; // Loader state
   logic [1:0] settle, next_settle; // Lets the strap synchroniser fill
   logic [2:0] step, next_step; // Load step: PROM word 0..3 at steps 0..3, config word 6 at step 4
   logic rd_start; // One-cycle request to the reader
   logic rd_busy, rd_done;
   logic [15:0] rd_data;
   logic rd_cs, rd_sk, rd_do;
   logic [5:0] rd_addr; // PROM word fetched at this step
   logic [15:0] rdata, next_rdata; // Read answer
   logic rvalid, next_rvalid;
   logic pin_do, pin_sk, pin_cs; // Registered pin drivers
   logic next_pin_do, next_pin_sk, next_pin_cs;
   logic wr_bank, wr_mac, wr_ctrl; // Decoded host writes
   logic [15:0] be_mask, wr_bits; // Byte lanes a host write touches, and its data there
   // Two-flop synchronisers for the strap and data input pins
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         en_meta <= 1'b0;
         en_sync <= 1'b0;
         di_meta <= 1'b0;
         di_sync <= 1'b0;
      end else begin
         en_meta <= i_prom_enable_pin;
         en_sync <= en_meta;
         di_meta <= i_prom_data_in_pin;
         di_sync <= di_meta;
      end
   end
   // Bank select answers at its offset whatever bank is active
   assign wr_bank = i_reg_wr && i_reg_addr == hcb_pkg::OFS_BANK_SEL;
   assign wr_mac = i_reg_wr && bank_select_field == hcb_pkg::BANK_MAC;
   assign wr_ctrl = i_reg_wr && bank_select_field == hcb_pkg::BANK_CTRL;
   assign be_mask = {{8{i_reg_be[1]}}, {8{i_reg_be[0]}}};
   assign wr_bits = i_reg_wdata & be_mask;
   // Words 0..3 sit at their own step number; the config word closes the load
   assign rd_addr = (step == hcb_pkg::LOAD_LAST_STEP) ? hcb_pkg::PROM_W_CONFIG :
                    {3'h0, step};
   // Next register values: host writes first, PROM load results override
   always_comb begin
      next_bank_select_field = bank_select_field;
      next_host_mac_addr_mid = host_mac_addr_mid;
      next_host_mac_addr_high = host_mac_addr_high;
      next_mac_low = mac_low;
      next_base_addr = base_addr;
      next_bus_speed_select = bus_speed_select;
      next_prom_sw_access_enable = prom_sw_access_enable;
      next_prom_pin_bits = prom_pin_bits;
      next_soft_rst = soft_rst;
      next_bus_width_status = bus_width_status;
      if (wr_bank && i_reg_be[0]) begin
         next_bank_select_field = i_reg_wdata[5:0];
      end
      if (wr_mac && i_reg_addr == hcb_pkg::OFS_MAC_MID) begin
         next_host_mac_addr_mid = (host_mac_addr_mid & ~be_mask) | wr_bits;
      end
      if (wr_mac && i_reg_addr == hcb_pkg::OFS_MAC_HIGH) begin
         next_host_mac_addr_high = (host_mac_addr_high & ~be_mask) | wr_bits;
      end
      if (wr_ctrl && i_reg_be[0]) begin // Control fields all sit in the low byte
         unique case (i_reg_addr)
            hcb_pkg::OFS_BUS_SPEED: next_bus_speed_select = i_reg_wdata[1:0];
            hcb_pkg::OFS_PROM_CTRL: begin
               next_prom_sw_access_enable = i_reg_wdata[hcb_pkg::BIT_PROM_SW_EN];
               next_prom_pin_bits = i_reg_wdata[hcb_pkg::BIT_PROM_DO:hcb_pkg::BIT_PROM_CS];
            end
            hcb_pkg::OFS_SOFT_RST: begin
               next_soft_rst = i_reg_wdata[hcb_pkg::BIT_SOFT_RST];
            end
            default: next_soft_rst = soft_rst; // Read-only offsets ignore writes
         endcase
      end
      // A finished PROM word lands in its register, winning over a host write
      if (rd_done && ld_state == LD_WAIT) begin
         unique case (step)
            3'h0: next_base_addr = rd_data & hcb_pkg::BASE_ADDR_MASK;
            3'h1: next_mac_low = rd_data;
            3'h2: next_host_mac_addr_mid = rd_data;
            3'h3: next_host_mac_addr_high = rd_data;
            default: begin // Config word: speed is all-fast or all-slow
               next_bus_speed_select = rd_data[hcb_pkg::CFG_BIT_SPEED] ?
                                       hcb_pkg::SPEED_25 : hcb_pkg::SPEED_125;
               next_bus_width_status = rd_data[hcb_pkg::CFG_BIT_WIDTH];
            end
         endcase
      end
   end
   // Register file flops; soft reset deliberately does not reach them
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bank_select_field <= hcb_pkg::BANK_RESET;
         host_mac_addr_mid <= hcb_pkg::WORD_ZERO;
         host_mac_addr_high <= hcb_pkg::WORD_ZERO;
         mac_low <= hcb_pkg::WORD_ZERO;
         base_addr <= hcb_pkg::BASE_ADDR_DEFAULT;
         bus_speed_select <= hcb_pkg::SPEED_125;
         prom_sw_access_enable <= 1'b0;
         prom_pin_bits <= 3'h0;
         soft_rst <= 1'b0;
         bus_width_status <= hcb_pkg::BUS_WIDTH_DEFAULT;
      end else begin
         bank_select_field <= next_bank_select_field;
         host_mac_addr_mid <= next_host_mac_addr_mid;
         host_mac_addr_high <= next_host_mac_addr_high;
         mac_low <= next_mac_low;
         base_addr <= next_base_addr;
         bus_speed_select <= next_bus_speed_select;
         prom_sw_access_enable <= next_prom_sw_access_enable;
         prom_pin_bits <= next_prom_pin_bits;
         soft_rst <= next_soft_rst;
         bus_width_status <= next_bus_width_status;
      end
   end
   // Loader sequence: settle, then fetch base, MAC words and config word
   always_comb begin
      next_ld_state = ld_state;
      next_settle = settle;
      next_step = step;
      rd_start = 1'b0;
      unique case (ld_state)
         LD_SETTLE: begin
            if (settle == hcb_pkg::STRAP_SETTLE) begin // Synchroniser holds the real pin
               next_ld_state = en_sync ? LD_ISSUE : LD_DONE;
            end else begin
               next_settle = settle + 2'h1;
            end
         end
         LD_ISSUE: begin
            rd_start = 1'b1;
            next_ld_state = LD_WAIT;
         end
         LD_WAIT: begin
            if (rd_done) begin
               if (step == hcb_pkg::LOAD_LAST_STEP) begin
                  next_ld_state = LD_DONE;
               end else begin
                  next_step = step + 3'h1;
                  next_ld_state = LD_ISSUE;
               end
            end
         end
         LD_DONE: next_ld_state = LD_DONE; // Load runs once per hardware reset
      endcase
   end
   // Loader flops
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ld_state <= LD_SETTLE;
         settle <= 2'h0;
         step <= 3'h0;
      end else begin
         ld_state <= next_ld_state;
         settle <= next_settle;
         step <= next_step;
      end
   end
   // Serial word reader used only by the loader
   hcb_prom_word_reader #(.HALF_CYC(SK_HALF_CYC)) u_reader (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(rd_start),
      .i_addr(rd_addr),
      .o_busy(rd_busy),
      .o_done(rd_done),
      .o_data(rd_data),
      .i_di(di_sync),
      .o_cs(rd_cs),
      .o_sk(rd_sk),
      .o_do(rd_do)
   );
   // Pin owner: loader while loading, else host bits if allowed, else idle low
   always_comb begin
      next_pin_do = 1'b0;
      next_pin_sk = 1'b0;
      next_pin_cs = 1'b0;
      if (ld_state == LD_ISSUE || ld_state == LD_WAIT) begin
         next_pin_do = rd_do;
         next_pin_sk = rd_sk;
         next_pin_cs = rd_cs;
      end else if (prom_sw_access_enable) begin
         // Host owns every edge of the serial timing here
         next_pin_do = prom_pin_bits[hcb_pkg::BIT_PROM_DO];
         next_pin_sk = prom_pin_bits[hcb_pkg::BIT_PROM_SK];
         next_pin_cs = prom_pin_bits[hcb_pkg::BIT_PROM_CS];
      end
   end
   // Read data mux; unmapped offsets read zero
   always_comb begin
      next_rdata = rdata;
      next_rvalid = i_reg_rd;
      if (i_reg_rd) begin
         next_rdata = hcb_pkg::WORD_ZERO;
         if (i_reg_addr == hcb_pkg::OFS_BANK_SEL) begin
            next_rdata[5:0] = bank_select_field;
         end else if (bank_select_field == hcb_pkg::BANK_MAC) begin
            if (i_reg_addr == hcb_pkg::OFS_MAC_MID) begin
               next_rdata = host_mac_addr_mid;
            end else if (i_reg_addr == hcb_pkg::OFS_MAC_HIGH) begin
               next_rdata = host_mac_addr_high;
            end
         end else if (bank_select_field == hcb_pkg::BANK_CTRL) begin
            unique case (i_reg_addr)
               hcb_pkg::OFS_BUS_SPEED: next_rdata[1:0] = bus_speed_select;
               hcb_pkg::OFS_PROM_CTRL: begin
                  next_rdata[hcb_pkg::BIT_PROM_SW_EN] = prom_sw_access_enable;
                  next_rdata[hcb_pkg::BIT_PROM_DI] = di_sync;
                  next_rdata[hcb_pkg::BIT_PROM_DO:hcb_pkg::BIT_PROM_CS] = prom_pin_bits;
               end
               hcb_pkg::OFS_SELFTEST: begin
                  next_rdata[hcb_pkg::BIT_TX_DONE] = i_tx_mem_selftest_done;
                  next_rdata[hcb_pkg::BIT_TX_FAIL] = i_tx_mem_selftest_fail;
                  next_rdata[hcb_pkg::BIT_RX_DONE] = i_rx_mem_selftest_done;
                  next_rdata[hcb_pkg::BIT_RX_FAIL] = i_rx_mem_selftest_fail;
               end
               hcb_pkg::OFS_SOFT_RST: next_rdata[hcb_pkg::BIT_SOFT_RST] = soft_rst;
               hcb_pkg::OFS_BUS_WIDTH: begin
                  next_rdata[hcb_pkg::BIT_BUS_WIDTH] = bus_width_status;
               end
               default: next_rdata = hcb_pkg::WORD_ZERO;
            endcase
         end
      end
   end
   // Answer and pin flops
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata <= hcb_pkg::WORD_ZERO;
         rvalid <= 1'b0;
         pin_do <= 1'b0;
         pin_sk <= 1'b0;
         pin_cs <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         pin_do <= next_pin_do;
         pin_sk <= next_pin_sk;
         pin_cs <= next_pin_cs;
      end
   end
   // Outputs from flops, except load busy, which ORs loader and reader state
   assign o_reg_rdata = rdata;
   assign o_reg_rvalid = rvalid;
   assign o_prom_data_out_pin = pin_do;
   assign o_prom_serial_clock_pin = pin_sk;
   assign o_prom_chip_select_pin = pin_cs;
   assign o_bus_speed_select = bus_speed_select;
   assign o_soft_reset = soft_rst; // Level held while the bit is set
   assign o_base_addr = base_addr;
   assign o_host_mac_addr_low = mac_low;
   assign o_host_mac_addr_mid = host_mac_addr_mid;
   assign o_host_mac_addr_high = host_mac_addr_high;
   assign o_bus_width_16 = bus_width_status;
   assign o_prom_load_busy = (ld_state != LD_DONE) || rd_busy;
endmodule
`default_nettype wire

//--- dv/hcb_bank_props.sv
// Checker for the host config bank
`timescale 1ns/100ps
`default_nettype none
module hcb_bank_props (
   input wire logic i_clk, i_sys_rst, i_reg_wr, i_reg_rd, o_reg_rvalid, o_soft_reset,
   input wire logic o_prom_load_busy, o_prom_data_out_pin, o_prom_serial_clock_pin,
   input wire logic o_prom_chip_select_pin, i_tx_mem_selftest_done, i_tx_mem_selftest_fail,
   input wire logic i_rx_mem_selftest_done, i_rx_mem_selftest_fail,
   input wire logic [3:0] i_reg_addr,
   input wire logic [1:0] i_reg_be, o_bus_speed_select,
   input wire logic [15:0] i_reg_wdata, o_reg_rdata, o_base_addr,
   input wire logic [15:0] o_host_mac_addr_mid, o_host_mac_addr_high
);
   logic [5:0] bank; // Bank shadow
   wire w3 = i_reg_wr && i_reg_be[0] && bank == 6'h03; // Bank 3 write
   wire w2 = i_reg_wr && i_reg_be == 2'h3 && bank == 6'h02 && !o_prom_load_busy; // MAC write
   // Track bank writes
   always_ff @(posedge i_clk or posedge i_sys_rst)
      if (i_sys_rst) bank <= 6'h00;
      else if (i_reg_wr && i_reg_be[0] && i_reg_addr == 4'hE) bank <= i_reg_wdata[5:0];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_read_answer: assert property (o_reg_rvalid == $past(i_reg_rd)) else $error("read answer");
   a_bank_readback: assert property (i_reg_rd && i_reg_addr == 4'hE |=>
      o_reg_rdata == {10'h000, $past(bank)}) else $error("bank readback");
   a_soft_set: assert property (w3 && i_reg_addr == 4'h6 |=>
      o_soft_reset == $past(i_reg_wdata[0])) else $error("soft reset write");
   a_soft_hold: assert property (!(w3 && i_reg_addr == 4'h6) |=> $stable(o_soft_reset))
      else $error("soft reset moved");
   a_speed_write: assert property (w3 && i_reg_addr == 4'h0 && !o_prom_load_busy |=>
      o_bus_speed_select == $past(i_reg_wdata[1:0])) else $error("speed write");
   a_mid_write: assert property (w2 && i_reg_addr == 4'h2 |=>
      o_host_mac_addr_mid == $past(i_reg_wdata)) else $error("mac mid write");
   a_high_write: assert property (w2 && i_reg_addr == 4'h4 |=>
      o_host_mac_addr_high == $past(i_reg_wdata)) else $error("mac high write");
   a_pin_drive: assert property (w3 && i_reg_addr == 4'h2 && !o_prom_load_busy |-> ##2
      {o_prom_data_out_pin, o_prom_serial_clock_pin, o_prom_chip_select_pin} ==
      ($past(i_reg_wdata[4], 2) ? $past(i_reg_wdata[2:0], 2) : 3'h0)) else $error("pins");
   a_selftest_read: assert property (i_reg_rd && bank == 6'h03 && i_reg_addr == 4'h4 |=>
      o_reg_rdata == $past({3'h0, i_tx_mem_selftest_done, i_tx_mem_selftest_fail, 6'h00,
      i_rx_mem_selftest_done, i_rx_mem_selftest_fail, 3'h0})) else $error("self test");
   a_base_kept: assert property (o_soft_reset |=> $stable(o_base_addr)) else $error("base");
   c_soft: cover property (o_soft_reset);
   c_loaded: cover property (!o_prom_load_busy && o_bus_speed_select == 2'h3);
   c_sw_pins: cover property (o_prom_chip_select_pin && !o_prom_load_busy);
endmodule
bind hcb_host_config_bank hcb_bank_props chk (.*);
`default_nettype wire

//--- dv/hcb_prom_model.sv
// Serial PROM model for word reads
`timescale 1ns/100ps
`default_nettype none
module hcb_prom_model (
   input wire logic i_cs,
   input wire logic i_sk,
   input wire logic i_do,
   output logic o_di
);
   logic [15:0] mem [64]; // Filled by the bench
   logic [5:0] addr = 6'h00;
   logic d = 1'b0;
   int n = 0; // Clock rises seen in this frame
   // Rises 4 to 9 carry the address
   always @(posedge i_sk)
      if (i_cs) begin
         n = n + 1;
         if (n > 3 && n < 10) addr = {addr[4:0], i_do};
      end
   // Dummy zero, then data MSB first on falling clock
   always @(negedge i_sk)
      if (i_cs && n >= 9 && n < 26) d = (n == 9) ? 1'b0 : mem[addr][25 - n];
   always @(posedge i_cs) n = 0;
   // Deselected: inverse, not stale
   assign o_di = i_cs ? d : ~d;
endmodule
`default_nettype wire

//--- dv/hcb_host_config_bank_tb.sv
// Bench for the host configuration bank
`timescale 1ns/100ps
`default_nettype none
module hcb_host_config_bank_tb;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_prom_enable_pin = 1'b1;
   logic i_prom_data_in_pin, o_reg_rvalid, o_prom_data_out_pin, o_prom_serial_clock_pin;
   logic o_prom_chip_select_pin, o_soft_reset, o_bus_width_16, o_prom_load_busy;
   logic i_tx_mem_selftest_done, i_tx_mem_selftest_fail;
   logic i_rx_mem_selftest_done, i_rx_mem_selftest_fail;
   logic [3:0] i_reg_addr = 4'h0;
   logic [1:0] i_reg_be = 2'h3, o_bus_speed_select;
   logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata, o_base_addr, o_host_mac_addr_low, d, q[$];
   logic [15:0] o_host_mac_addr_mid, o_host_mac_addr_high;
   logic [31:0] s = 32'd23; // Xorshift state
   int failures = 0, check_count = 0;
   hcb_host_config_bank #(.SK_HALF_CYC(4)) uut (.*);
   hcb_prom_model prom (.i_cs(o_prom_chip_select_pin), .i_sk(o_prom_serial_clock_pin),
      .i_do(o_prom_data_out_pin), .o_di(i_prom_data_in_pin));
   always #5 i_clk = ~i_clk;
   function automatic logic [15:0] rnd();
      s ^= s << 13; s ^= s >> 17; s ^= s << 5;
      return s[15:0];
   endfunction
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // One access; a read queues its expected word
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v, input logic [15:0] e);
      @(posedge i_clk);
      i_reg_wr <= w; i_reg_rd <= !w; i_reg_addr <= a; i_reg_wdata <= v;
      if (!w) q.push_back(e);
      @(posedge i_clk);
      i_reg_wr <= 1'b0; i_reg_rd <= 1'b0;
   endtask
   task automatic wait_load();
      for (int k = 0; k < 3000 && o_prom_load_busy; k++) @(posedge i_clk);
      if (o_prom_load_busy) failures++;
   endtask
   task automatic summarize();
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Answers against the oldest note
   always @(posedge i_clk) if (o_reg_rvalid) cmp(o_reg_rdata, q.pop_front());
   initial begin
      #100000; failures++; summarize();
   end
   initial begin
      for (int i = 0; i < 7; i++) prom.mem[i] = rnd();
      prom.mem[6][1:0] = 2'h2; // Slow bus, narrow width
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      wait_load();
      cmp(o_base_addr, prom.mem[0] & 16'hFFE0);
      cmp(o_host_mac_addr_low, prom.mem[1]);
      cmp(o_host_mac_addr_mid, prom.mem[2]);
      cmp(o_host_mac_addr_high, prom.mem[3]);
      cmp(16'(o_bus_speed_select), 16'h0003);
      cmp(16'(o_bus_width_16), 16'h0000);
      acc(1, 4'hE, 16'h0003, 0);
      acc(0, 4'h8, 0, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         acc(1, 4'h0, 16'(i), 0);
         @(posedge i_clk) cmp(16'(o_bus_speed_select), 16'(i));
         d = rnd();
         {i_tx_mem_selftest_done, i_tx_mem_selftest_fail, i_rx_mem_selftest_done,
            i_rx_mem_selftest_fail} <= d[3:0];
         acc(0, 4'h4, 0, {3'h0, d[3:2], 6'h00, d[1:0], 3'h0});
      end
      for (int i = 0; i < 6; i++) begin
         d = rnd() & 16'h001F;
         acc(1, 4'h2, d, 0);
         repeat (3) @(posedge i_clk);
         cmp(16'({o_prom_data_out_pin, o_prom_serial_clock_pin, o_prom_chip_select_pin}),
            16'(d[4] ? d[2:0] : 3'h0));
         acc(0, 4'h2, 0, {11'h0, d[4], i_prom_data_in_pin, d[2:0]});
      end
      acc(1, 4'h6, 16'h0001, 0);
      repeat (5) @(posedge i_clk);
      cmp(16'(o_soft_reset), 16'h0001);
      cmp(o_base_addr, prom.mem[0] & 16'hFFE0);
      acc(1, 4'h6, 16'h0000, 0);
      @(posedge i_clk) cmp(16'(o_soft_reset), 16'h0000);
      d = rnd();
      acc(1, 4'hE, 16'h0002, 0);
      acc(0, 4'hE, 0, 16'h0002);
      acc(1, 4'h2, d, 0);
      acc(0, 4'h2, 0, d);
      acc(1, 4'h4, ~d, 0);
      acc(0, 4'h4, 0, ~d);
      @(posedge i_clk) i_prom_enable_pin <= 1'b0;
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      wait_load();
      cmp(o_base_addr, 16'h0300);
      cmp(o_host_mac_addr_high, 16'h0000);
      cmp(16'(o_bus_width_16), 16'h0001);
      summarize();
   end
endmodule
`default_nettype wire
